// *** core/prx_top.sv ***
// proximity sensor control: emitter burst, conversion, alert, apb and two-wire target
//
// Register access over APB and the register offsets were left to the implementer.

// Behaviour
// - open-drain alert level, held until firmware clears
// - flag result above upper or below lower
// - alert after programmed consecutive out-of-range count
// - thresholds and persistence are separate registers
// - burst of 1 to 255 emitter pulses
// - each pulse period is 16 us
// - emitter on about 8 us per period
// - wait timer from 2.7 ms to over 8 s
// - two-wire target access up to 400 kHz
// - result clamped at 1023 counts
// - one conversion step of 2.73 ms
module prx_top #(
  parameter int unsigned INTEG_CYCLES = prx_pkg::INTEG_CYC,     // conversion length
  parameter int unsigned WAIT_CYCLES  = prx_pkg::WAIT_STEP_CYC, // one wait step
  parameter logic [6:0]  TWI_ADDR     = 7'h2A                   // arbitrary target address
) (
  input  wire logic        mclk,                    // 40 MHz clock
  input  wire logic        rst,                     // sync reset, high
  input  wire logic [7:0]  paddr,                   // apb address
  input  wire logic        psel,                    // apb select
  input  wire logic        penable,                 // apb enable
  input  wire logic        pwrite,                  // apb direction
  input  wire logic [31:0] pwdata,                  // apb write data
  output logic      [31:0] prdata,                  // apb read data
  output logic             pready,                  // apb ready
  output logic             pslverr,                 // apb error, unmapped
  output logic             irq,                     // level interrupt
  input  wire logic        scl_pin,                 // two-wire clock pin
  input  wire logic        sda_i,                   // two-wire data in
  output logic             sda_o,                   // two-wire data out
  output logic             sda_oe_n,                // low while pulling sda
  output logic             alert_o,                 // alert pin level
  output logic             alert_oe_n,              // low while alert pulled
  output logic             emitter_drive_sink_o,    // emitter sink level
  output logic             emitter_drive_sink_oe_n, // low while emitter on
  input  wire logic [11:0] adc_acc,                 // reflected-light accumulator
  output logic             adc_clear                // accumulator clear pulse
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [3:0]                ctrl;
  logic [7:0]                pulses;
  logic [7:0]                wtime;
  logic [9:0]                thr_lo;
  logic [9:0]                thr_hi;
  logic [3:0]                pers;
  logic [9:0]                result;
  logic [1:0]                status;
  logic [1:0]                mask;
  prx_pkg::prx_meas_e        mst;
  logic [prx_pkg::TMR_W-1:0] tmr;
  logic [7:0]                pulse_left;
  logic [11:0]               wait_left;
  logic [11:0]               wait_steps;
  logic                      emit_on;
  logic [3:0]                pers_cnt;
  logic [3:0]                pers_need;
  logic [9:0]                conv_val;
  logic                      oor;
  logic                      set_alert;
  logic [1:0]                st_set;
  logic [1:0]                st_clr;
  logic                      apb_setup;
  logic                      apb_wr;
  logic                      err_q;
  logic                      wr_en;
  logic [7:0]                wr_addr;
  logic [31:0]               wr_data;
  logic [3:0]                wr_be;
  logic                      scl_s;
  logic                      sda_s;
  logic                      scl_d;
  logic                      sda_d;
  logic                      tw_start;
  logic                      tw_stop;
  logic                      tw_rise;
  logic                      tw_fall;
  prx_pkg::prx_i2c_e         ist;
  logic [3:0]                bitcnt;
  logic [7:0]                shreg;
  logic [7:0]                txsh;
  logic [7:0]                ptr;
  logic                      rw;
  logic                      sda_low;
  logic                      tw_wr;
  logic [31:0]               tw_word;
  logic [7:0]                rd_byte;
  logic [32:0]               apb_rv;
  logic [32:0]               tw_rv;
  logic [32:0]               wr_rv;
  logic [31:0]               wr_mrg;

  // ----------------------------------------------------------------
  // register read and merge helpers
  // ----------------------------------------------------------------
  function automatic logic [32:0] regval(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case (a)
      prx_pkg::A_CTRL:   r[31:0] = 32'(ctrl);
      prx_pkg::A_PULSES: r[31:0] = 32'(pulses);
      prx_pkg::A_WTIME:  r[31:0] = 32'(wtime);
      prx_pkg::A_THR_LO: r[31:0] = 32'(thr_lo);
      prx_pkg::A_THR_HI: r[31:0] = 32'(thr_hi);
      prx_pkg::A_PERS:   r[31:0] = 32'(pers);
      prx_pkg::A_RESULT: r[31:0] = 32'(result);
      prx_pkg::A_STATUS: r[31:0] = 32'(status);
      prx_pkg::A_MASK:   r[31:0] = 32'(mask);
      default:           r[32] = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int k = 0; k < 4; k++)
    begin
      if (be[k])
        m[8*k +: 8] = nw[8*k +: 8];
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // apb slave, one setup plus one access cycle
  // ----------------------------------------------------------------
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;
  assign pready    = psel & penable;
  assign pslverr   = psel & penable & err_q;

  // register views for both buses and the write merge, addresses word-aligned at each call
  always_comb
  begin
    apb_rv = regval({paddr[7:2], 2'b00});
    tw_rv  = regval({ptr[7:2], 2'b00});
    wr_rv  = regval(wr_addr);
    wr_mrg = merge(wr_rv[31:0], wr_data, wr_be);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
      err_q  <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata <= apb_rv[31:0];
      err_q  <= ~apb_rv[32];
    end
  end

  // apb wins over a two-wire byte in the same cycle
  assign wr_en   = apb_wr | tw_wr;
  assign wr_addr = apb_wr ? {paddr[7:2], 2'b00} : {ptr[7:2], 2'b00};
  assign wr_data = apb_wr ? pwdata : {4{shreg}};
  assign wr_be   = apb_wr ? 4'hF : (4'h1 << ptr[1:0]);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // separate threshold registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl   <= prx_pkg::CTRL_RST;
      pulses <= prx_pkg::PULSES_RST;
      wtime  <= prx_pkg::WTIME_RST;
      thr_lo <= prx_pkg::THR_LO_RST;
      thr_hi <= prx_pkg::THR_HI_RST;
      pers   <= prx_pkg::PERS_RST;
      mask   <= 2'h0;
    end
    else if (wr_en)
    begin
      case (wr_addr)
        prx_pkg::A_CTRL:   ctrl   <= wr_mrg[3:0];
        prx_pkg::A_PULSES: pulses <= wr_mrg[7:0];
        prx_pkg::A_WTIME:  wtime  <= wr_mrg[7:0];
        prx_pkg::A_THR_LO: thr_lo <= wr_mrg[9:0];
        prx_pkg::A_THR_HI: thr_hi <= wr_mrg[9:0];
        prx_pkg::A_PERS:   pers   <= wr_mrg[3:0];
        prx_pkg::A_MASK:   mask   <= wr_mrg[1:0];
        default:           ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status, interrupt and alert pin
  // ----------------------------------------------------------------
  assign st_clr = (wr_en && wr_addr == prx_pkg::A_STATUS && wr_be[0]) ? wr_data[1:0] : 2'h0;
  assign st_set = {mst == prx_pkg::M_CHECK, set_alert};

  always_ff @(posedge mclk)
  begin
    if (rst)
      status <= 2'h0;
    else
      status <= (status & ~st_clr) | st_set;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq        <= 1'b0;
      alert_oe_n <= 1'b1;
    end
    else
    begin
      irq        <= |(((status & ~st_clr) | st_set) & mask);
      alert_oe_n <= ~((status[prx_pkg::ST_ALERT] & ~st_clr[prx_pkg::ST_ALERT]) | set_alert);
    end
  end

  assign alert_o              = 1'b0;
  assign emitter_drive_sink_o = 1'b0;
  assign sda_o                = 1'b0;

  // ----------------------------------------------------------------
  // measurement sequencer
  // ----------------------------------------------------------------
  // wait length in steps
  assign wait_steps = ctrl[prx_pkg::CTRL_LONG] ? 12'((12'(wtime) + 12'h001) * prx_pkg::LONG_WAIT_MULT)
                                               : 12'(wtime) + 12'h001;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mst        <= prx_pkg::M_IDLE;
      tmr        <= '0;
      pulse_left <= 8'h00;
      wait_left  <= 12'h000;
      adc_clear  <= 1'b0;
    end
    else
    begin
      adc_clear <= 1'b0;
      case (mst)
        prx_pkg::M_IDLE:
          if (ctrl[prx_pkg::CTRL_EN])
          begin
            mst        <= prx_pkg::M_PULSE;
            tmr        <= '0;
            pulse_left <= (pulses == 8'h00) ? 8'h01 : pulses;
            adc_clear  <= 1'b1;
          end
        prx_pkg::M_PULSE:
          if (tmr == prx_pkg::TMR_W'(prx_pkg::PULSE_CYC - 1))
          begin
            tmr <= '0;
            if (pulse_left == 8'h01)
              mst <= prx_pkg::M_INTEG;
            else
              pulse_left <= pulse_left - 8'h01;
          end
          else
            tmr <= tmr + 1'b1;
        prx_pkg::M_INTEG:
          if (tmr == prx_pkg::TMR_W'(INTEG_CYCLES - 1))
          begin
            tmr <= '0;
            mst <= prx_pkg::M_CHECK;
          end
          else
            tmr <= tmr + 1'b1;
        prx_pkg::M_CHECK:
          if (ctrl[prx_pkg::CTRL_WAIT_EN])
          begin
            mst       <= prx_pkg::M_WAIT;
            wait_left <= wait_steps;
          end
          else
            mst <= prx_pkg::M_IDLE;
        prx_pkg::M_WAIT:
          if (!ctrl[prx_pkg::CTRL_EN])
          begin
            tmr <= '0;
            mst <= prx_pkg::M_IDLE;
          end
          else if (tmr == prx_pkg::TMR_W'(WAIT_CYCLES - 1))
          begin
            tmr <= '0;
            if (wait_left == 12'h001)
              mst <= prx_pkg::M_IDLE;
            else
              wait_left <= wait_left - 12'h001;
          end
          else
            tmr <= tmr + 1'b1;
        default:
          mst <= prx_pkg::M_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      emit_on <= 1'b0;
    else
      emit_on <= (mst == prx_pkg::M_PULSE) && (tmr < prx_pkg::TMR_W'(prx_pkg::EMIT_ON_CYC));
  end

  assign emitter_drive_sink_oe_n = ~emit_on;

  // ----------------------------------------------------------------
  // result, threshold compare, persistence
  // ----------------------------------------------------------------
  // clamp to full scale
  assign conv_val  = (adc_acc > 12'(prx_pkg::RES_MAX)) ? prx_pkg::RES_MAX : adc_acc[9:0];
  assign oor       = (conv_val > thr_hi) || (conv_val < thr_lo);
  assign pers_need = (pers == 4'h0) ? 4'h1 : pers;
  assign set_alert = (mst == prx_pkg::M_CHECK) && ctrl[prx_pkg::CTRL_ALERT_EN] && oor &&
                     ((5'(pers_cnt) + 5'h01) >= 5'(pers_need));

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      result   <= 10'h000;
      pers_cnt <= 4'h0;
    end
    else if (mst == prx_pkg::M_CHECK)
    begin
      result <= conv_val;
      if (ctrl[prx_pkg::CTRL_ALERT_EN] && oor)
        pers_cnt <= (pers_cnt == 4'hF) ? pers_cnt : pers_cnt + 4'h1;
      else
        pers_cnt <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // two-wire target
  // ----------------------------------------------------------------
  prx_sync #(
    .W (2)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({scl_pin, sda_i}),
    .q    ({scl_s, sda_s})
  );

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign tw_start = scl_s & scl_d & sda_d & ~sda_s;
  assign tw_stop  = scl_s & scl_d & ~sda_d & sda_s;
  assign tw_rise  = scl_s & ~scl_d;
  assign tw_fall  = ~scl_s & scl_d;
  assign tw_wr    = tw_fall && (ist == prx_pkg::I_WDATA) && (bitcnt == prx_pkg::I2C_BITS);
  assign tw_word  = tw_rv[31:0];
  assign rd_byte  = tw_word[8*ptr[1:0] +: 8];
  assign sda_oe_n = ~sda_low;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ist     <= prx_pkg::I_IDLE;
      bitcnt  <= 4'h0;
      shreg   <= 8'h00;
      txsh    <= 8'h00;
      ptr     <= 8'h00;
      rw      <= 1'b0;
      sda_low <= 1'b0;
    end
    else if (tw_start)
    begin
      ist     <= prx_pkg::I_ADDR;
      bitcnt  <= 4'h0;
      sda_low <= 1'b0;
    end
    else if (tw_stop)
    begin
      ist     <= prx_pkg::I_IDLE;
      sda_low <= 1'b0;
    end
    else if (tw_rise)
    begin
      case (ist)
        prx_pkg::I_ADDR, prx_pkg::I_PTR, prx_pkg::I_WDATA:
        begin
          shreg  <= {shreg[6:0], sda_s};
          bitcnt <= bitcnt + 4'h1;
        end
        prx_pkg::I_RDATA: bitcnt <= bitcnt + 4'h1;
        prx_pkg::I_ACK_R: if (sda_s) ist <= prx_pkg::I_IDLE;
        default:          ;
      endcase
    end
    else if (tw_fall)
    begin
      case (ist)
        prx_pkg::I_ADDR:
          if (bitcnt == prx_pkg::I2C_BITS)
          begin
            if (shreg[7:1] == TWI_ADDR)
            begin
              sda_low <= 1'b1;
              rw      <= shreg[0];
              ist     <= prx_pkg::I_ACK_A;
            end
            else
              ist <= prx_pkg::I_IDLE;
          end
        prx_pkg::I_ACK_A, prx_pkg::I_ACK_R:
        begin
          bitcnt <= 4'h0;
          if (rw)
          begin
            sda_low <= ~rd_byte[7];
            txsh    <= {rd_byte[6:0], 1'b0};
            ist     <= prx_pkg::I_RDATA;
          end
          else
          begin
            sda_low <= 1'b0;
            ist     <= prx_pkg::I_PTR;
          end
        end
        prx_pkg::I_PTR:
          if (bitcnt == prx_pkg::I2C_BITS)
          begin
            ptr     <= shreg;
            sda_low <= 1'b1;
            ist     <= prx_pkg::I_ACK_P;
          end
        prx_pkg::I_ACK_P, prx_pkg::I_ACK_W:
        begin
          sda_low <= 1'b0;
          bitcnt  <= 4'h0;
          ist     <= prx_pkg::I_WDATA;
        end
        prx_pkg::I_WDATA:
          if (bitcnt == prx_pkg::I2C_BITS)
          begin
            ptr     <= ptr + 8'h01;
            sda_low <= 1'b1;
            ist     <= prx_pkg::I_ACK_W;
          end
        prx_pkg::I_RDATA:
          if (bitcnt == prx_pkg::I2C_BITS)
          begin
            ptr     <= ptr + 8'h01;
            sda_low <= 1'b0;
            ist     <= prx_pkg::I_ACK_R;
          end
          else
          begin
            sda_low <= ~txsh[7];
            txsh    <= {txsh[6:0], 1'b0};
          end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic [prx_pkg::TMR_W-1:0] on_len;

  always_ff @(posedge mclk)
  begin
    if (rst)
      on_len <= '0;
    else
      on_len <= emit_on ? on_len + 1'b1 : '0;
  end

  property p_alert_hold;
    (!alert_oe_n && st_clr[prx_pkg::ST_ALERT] == 1'b0) |=> !alert_oe_n;
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert released without clear");

  property p_oor_counts;
    (mst == prx_pkg::M_CHECK && ctrl[prx_pkg::CTRL_ALERT_EN] && oor) |=> (pers_cnt != 4'h0);
  endproperty
  a_oor_counts: assert property (p_oor_counts) else $error("out-of-range not counted");

  property p_persist;
    (mst == prx_pkg::M_CHECK && !set_alert && status[prx_pkg::ST_ALERT] == 1'b0)
      |=> (status[prx_pkg::ST_ALERT] == 1'b0) ##1 (alert_oe_n);
  endproperty
  a_persist: assert property (p_persist) else $error("alert raised early");

  property p_thr_own;
    $changed(thr_hi) |-> $past(wr_en && wr_addr == prx_pkg::A_THR_HI);
  endproperty
  a_thr_own: assert property (p_thr_own) else $error("upper threshold changed unasked");

  sequence s_last_pulse;
    mst == prx_pkg::M_PULSE && tmr == prx_pkg::TMR_W'(prx_pkg::PULSE_CYC - 1) && pulse_left == 8'h01;
  endsequence
  property p_burst_end;
    s_last_pulse |=> (mst == prx_pkg::M_INTEG && tmr == '0);
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst did not end");

  property p_period;
    (mst == prx_pkg::M_PULSE && tmr == prx_pkg::TMR_W'(prx_pkg::PULSE_CYC - 1) &&
     pulse_left > 8'h01) |=> (tmr == '0) ##1 emit_on;
  endproperty
  a_period: assert property (p_period) else $error("pulse period wrong");

  property p_on_time;
    $fell(emit_on) |-> (on_len == prx_pkg::TMR_W'(prx_pkg::EMIT_ON_CYC));
  endproperty
  a_on_time: assert property (p_on_time) else $error("emitter on time wrong");

  property p_wait_load;
    (mst == prx_pkg::M_CHECK && ctrl[prx_pkg::CTRL_WAIT_EN])
      |=> (mst == prx_pkg::M_WAIT && wait_left == $past(wait_steps));
  endproperty
  a_wait_load: assert property (p_wait_load) else $error("wait not loaded");

  property p_addr_ack;
    (tw_fall && !tw_start && !tw_stop && ist == prx_pkg::I_ADDR &&
     bitcnt == prx_pkg::I2C_BITS && shreg[7:1] == TWI_ADDR) |=> !sda_oe_n;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

  property p_clamp;
    (mst == prx_pkg::M_CHECK && adc_acc > 12'(prx_pkg::RES_MAX)) |=> (result == prx_pkg::RES_MAX);
  endproperty
  a_clamp: assert property (p_clamp) else $error("result not clamped");

endmodule

// *** core/prx_pkg.sv ***
// constants, register map and state codes of the proximity block
package prx_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS          = 25;
  localparam int unsigned PULSE_PERIOD_NS = 16000;
  localparam int unsigned PULSE_CYC       = (PULSE_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned EMIT_ON_NS      = 8000;
  localparam int unsigned EMIT_ON_CYC     = EMIT_ON_NS / CLK_NS;
  localparam int unsigned INTEG_NS        = 2730000;
  localparam int unsigned INTEG_CYC       = INTEG_NS / CLK_NS;
  localparam int unsigned WAIT_STEP_NS    = 2730000;
  localparam int unsigned WAIT_STEP_CYC   = WAIT_STEP_NS / CLK_NS;
  localparam logic [11:0] LONG_WAIT_MULT  = 12'h00C;
  localparam int unsigned TMR_W           = 18;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_PULSES = 8'h04;
  localparam logic [7:0] A_WTIME  = 8'h08;
  localparam logic [7:0] A_THR_LO = 8'h0C;
  localparam logic [7:0] A_THR_HI = 8'h10;
  localparam logic [7:0] A_PERS   = 8'h14;
  localparam logic [7:0] A_RESULT = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_MASK   = 8'h20;

  // ctrl fields and status fields
  localparam int unsigned CTRL_EN       = 0;
  localparam int unsigned CTRL_ALERT_EN = 1;
  localparam int unsigned CTRL_WAIT_EN  = 2;
  localparam int unsigned CTRL_LONG     = 3;
  localparam int unsigned ST_ALERT      = 0;
  localparam int unsigned ST_READY      = 1;

  // reset values, result full scale and bits per two-wire byte
  localparam logic [3:0] CTRL_RST   = 4'h0;
  localparam logic [7:0] PULSES_RST = 8'h08;
  localparam logic [7:0] WTIME_RST  = 8'h00;
  localparam logic [9:0] THR_LO_RST = 10'h000;
  localparam logic [9:0] THR_HI_RST = 10'h3FF;
  localparam logic [3:0] PERS_RST   = 4'h0;
  localparam logic [9:0] RES_MAX    = 10'h3FF;
  localparam logic [3:0] I2C_BITS   = 4'h8;

  // ----------------------------------------------------------------
  // state codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    M_IDLE  = 5'b00001,
    M_PULSE = 5'b00010,
    M_INTEG = 5'b00100,
    M_CHECK = 5'b01000,
    M_WAIT  = 5'b10000
  } prx_meas_e;

  typedef enum logic [8:0] {
    I_IDLE  = 9'b000000001,
    I_ADDR  = 9'b000000010,
    I_ACK_A = 9'b000000100,
    I_PTR   = 9'b000001000,
    I_ACK_P = 9'b000010000,
    I_WDATA = 9'b000100000,
    I_ACK_W = 9'b001000000,
    I_RDATA = 9'b010000000,
    I_ACK_R = 9'b100000000
  } prx_i2c_e;

endpackage

// *** core/prx_sync.sv ***
// two-flop synchroniser for pin inputs
module prx_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         mclk, // system clock
  input  wire logic         rst,  // sync reset, high
  input  wire logic [W-1:0] d,    // asynchronous inputs
  output logic      [W-1:0] q     // synchronised outputs
);

  logic [W-1:0] meta;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meta <= '1;
      q    <= '1;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// *** test/prx_ctl_model.sv ***
// two-wire controller model facing the block
module prx_ctl_model (
  output logic      scl,    // bus clock, idle high
  output logic      sda_pd, // high pulls sda low
  input  wire logic sda     // resolved data line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx; // bits seen on sda while scl is high
  initial
  begin
    scl = 1'h1;
    sda_pd = 1'h0;
  end
  task automatic bt(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--)
    begin
      #60 sda_pd = ~b[i];
      #40 scl = 1'h1;
      #50 rx[i] = sda;
      #50 scl = 1'h0;
    end
    #60 sda_pd = 1'h0;
    #40 scl = 1'h1;
    #50 a = ~sda;
    #50 scl = 1'h0;
  endtask
  task automatic wr(input logic [6:0] t, input logic [7:0] p, d, output logic [1:0] n);
    logic a;
    #100 sda_pd = 1'h1;
    #100 scl = 1'h0;
    bt({t, 1'h0}, a);
    n = {1'h0, a};
    bt(p, a);
    n = n + {1'h0, a};
    bt(d, a);
    n = n + {1'h0, a};
    #60 sda_pd = 1'h1;
    #40 scl = 1'h1;
    #100 sda_pd = 1'h0;
    #100;
  endtask
  // pointer write, repeated start, one byte read
  task automatic rdt(input logic [6:0] t, input logic [7:0] p, output logic [7:0] d);
    logic a;
    #100 sda_pd = 1'h1;
    #100 scl = 1'h0;
    bt({t, 1'h0}, a);
    bt(p, a);
    #60 sda_pd = 1'h0;
    #40 scl = 1'h1;
    #100 sda_pd = 1'h1;
    #100 scl = 1'h0;
    bt({t, 1'h1}, a);
    bt(8'hFF, a);
    d = rx;
    #60 sda_pd = 1'h1;
    #40 scl = 1'h1;
    #100 sda_pd = 1'h0;
    #100;
  endtask
endmodule

// *** test/proximity_pulse_and_alert_tb_top.sv ***
// self-checking bench of the proximity block
module proximity_pulse_and_alert_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [11:0] adc_acc = 12'h000;
  logic        pready, pslverr, irq, scl, sda, sda_pd, sda_o, sda_oe_n, er, em_q;
  logic        alert_o, alert_oe_n, em_o, em_oe_n, adc_clear;
  logic [1:0]  n;
  logic [7:0]  rb;
  int          err_count = 0, total_checks = 0, on_cnt = 0, cyc = 0, t0 = 0, per = 0, gap = 0;
  always #12.5 mclk = ~mclk;
  assign sda = (sda_oe_n | sda_o) & ~sda_pd;
  prx_ctl_model ctl (.scl(scl), .sda_pd(sda_pd), .sda(sda));
  prx_top #(.INTEG_CYCLES(200), .WAIT_CYCLES(100)) uut (.mclk(mclk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .scl_pin(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .alert_o(alert_o),
    .alert_oe_n(alert_oe_n), .emitter_drive_sink_o(em_o),
    .emitter_drive_sink_oe_n(em_oe_n), .adc_acc(adc_acc), .adc_clear(adc_clear));
  always @(posedge mclk)
  begin
    cyc++;
    em_q <= em_oe_n;
    if (em_oe_n === 1'h0)
      on_cnt++;
    if (em_oe_n === 1'h0 && em_q === 1'h1)
    begin
      if (cyc - t0 > 640)
        gap = cyc - t0;
      per = cyc - t0;
      t0 = cyc;
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do
      @(posedge mclk);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask
  // wait for the interrupt level
  task automatic meas;
    int k;
    k = 0;
    repeat (2) @(posedge mclk);
    while (irq !== 1'h1 && k < 4000)
    begin
      @(posedge mclk);
      k++;
    end
    chk("irq", {31'h0, irq}, 32'h1);
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    apb(1'h0, prx_pkg::A_PULSES, 32'h0);
    chk("pulses", rd, 32'h8);
    apb(1'h0, prx_pkg::A_THR_HI, 32'h0);
    chk("thr_hi", rd, 32'h3FF);
    apb(1'h0, 8'h3C, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    $display("test registers done");
    adc_acc <= 12'hFFF;
    apb(1'h1, prx_pkg::A_PULSES, 32'h2);
    apb(1'h1, prx_pkg::A_THR_HI, 32'h100);
    apb(1'h1, prx_pkg::A_PERS, 32'h2);
    apb(1'h1, prx_pkg::A_MASK, 32'h2);
    on_cnt = 0;
    apb(1'h1, prx_pkg::A_CTRL, 32'h7);
    meas;
    chk("on", on_cnt, 640);
    chk("period", per, 640);
    chk("alert1", alert_oe_n, 1'h1);
    apb(1'h0, prx_pkg::A_RESULT, 32'h0);
    chk("clamp", rd, 32'h3FF);
    apb(1'h1, prx_pkg::A_STATUS, 32'h2);
    meas;
    chk("alert2", alert_oe_n, 1'h0);
    chk("wait", gap, 942);
    apb(1'h1, prx_pkg::A_CTRL, 32'h0);
    apb(1'h1, prx_pkg::A_STATUS, 32'h2);
    repeat (200) @(posedge mclk);
    chk("hold", {alert_oe_n, irq}, 2'h0);
    apb(1'h1, prx_pkg::A_STATUS, 32'h3);
    repeat (2) @(posedge mclk);
    chk("release", {alert_oe_n, irq}, 2'h2);
    $display("test upper burst done");
    adc_acc <= 12'h005;
    apb(1'h1, prx_pkg::A_MASK, 32'h1);
    apb(1'h1, prx_pkg::A_THR_LO, 32'h10);
    apb(1'h1, prx_pkg::A_THR_HI, 32'h3FF);
    apb(1'h1, prx_pkg::A_PERS, 32'h0);
    apb(1'h1, prx_pkg::A_CTRL, 32'hF);
    meas;
    chk("low", alert_oe_n, 1'h0);
    apb(1'h1, prx_pkg::A_STATUS, 32'h3);
    meas;
    chk("long", gap, 2042);
    apb(1'h1, prx_pkg::A_CTRL, 32'h0);
    apb(1'h1, prx_pkg::A_STATUS, 32'h3);
    $display("test lower done");
    ctl.wr(7'h2A, prx_pkg::A_PULSES, 8'h05, n);
    chk("acks", n, 2'h3);
    ctl.wr(7'h2B, prx_pkg::A_PULSES, 8'h09, n);
    chk("nack", n, 2'h0);
    @(posedge mclk);
    apb(1'h0, prx_pkg::A_PULSES, 32'h0);
    chk("twi", rd, 32'h5);
    ctl.rdt(7'h2A, prx_pkg::A_PULSES, rb);
    chk("twi_rd", rb, 8'h05);
    $display("test two-wire done");
    results;
  end
  initial
  begin
    #1000000;
    err_count++;
    results;
  end
endmodule
